//--- hw/channel_alarm_status_bits.sv
// Operation
// - bit 4 is read-only, resets to 0 and shows the analog loss-of-signal state.
// - the analog detector declares below one amplitude level and clears above a higher one.
// - the channel loss-of-signal state is the OR of the analog and digital detectors.
// - that combined loss-of-signal state is reported in bit 1 of the status register.
// - bit 3 is read-only, resets to 0 and shows fifo within two bits of a limit.
// - the fifo alarm clears by itself once the fill leaves the two-bit margin.
// - the fifo alarm stays low while the jitter attenuator is disabled.
// - loss-of-lock is declared when recovered clock is 0.5 percent off the rate reference.
// - in single-reference mode the recovered clock is compared to the synthesized clock.
// - bit 2 is read-only, resets to 0 and shows the loss-of-lock state.
// - the digital detector declares after 160 bit periods without a pulse.
// - the digital detector clears once pulse density reaches 33 percent.
`include "chan_alarm_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module channel_alarm_status_bits (
  input wire logic ref_clk, // 10 MHz system clock
  input wire logic reset, // synchronous, active high
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  output logic irq, // level interrupt
  input wire logic [7:0] analog_amp, // measured pulse amplitude
  input wire logic rx_bit_en, // one pulse per received bit
  input wire logic rx_pulse, // pulse present in this bit
  input wire logic [5:0] ja_fifo_fill, // jitter attenuator fill level
  input wire logic recov_clk_toggle, // recovered clock, divided
  input wire logic e3_rate_ref_clock, // e3 reference, divided
  input wire logic ds3_rate_ref_clock, // ds3 reference, divided
  input wire logic sts1_rate_ref_clock, // sts-1 reference, divided
  input wire logic synth_line_clock // synthesized line clock, divided
);

  // functions
  function automatic logic density_ok(input logic [5:0] ones);
    logic [12:0] lhs;
    logic [12:0] rhs;
    lhs = 13'(ones) * 13'd100;
    rhs = 13'(`DLOS_DENSITY_PCT) * 13'(`DLOS_WIN);
    return lhs >= rhs;
  endfunction

  function automatic logic freq_off(input logic [11:0] cnt);
    logic [11:0] dev;
    logic [39:0] lhs;
    logic [39:0] rhs;
    dev = (cnt >= `LOL_WIN) ? cnt - `LOL_WIN : `LOL_WIN - cnt;
    lhs = 40'(dev) * 40'd1000000;
    rhs = `LOL_LIMIT_PPM * 40'(`LOL_WIN);
    return lhs >= rhs;
  endfunction

  function automatic logic [7:0] alarm_byte(input chan_alarm_pkg::alarm_s a);
    logic [7:0] b;
    b = 8'h00;
    b[`BIT_ANALOG] = a.analog;
    b[`BIT_FIFO] = a.fifo;
    b[`BIT_LOL] = a.recovered_clock_unlocked;
    b[`BIT_COMB] = a.comb;
    return b;
  endfunction

  function automatic logic wr_hit(input chan_alarm_pkg::reg_req_s r, input logic [7:0] a);
    return r.wr && r.addr == a;
  endfunction

  // declarations
  chan_alarm_pkg::reg_req_s req;
  chan_alarm_pkg::ctrl_s ctrl_ff;
  chan_alarm_pkg::alarm_s status_ff;
  chan_alarm_pkg::alarm_s prev_ff;
  chan_alarm_pkg::alarm_s nxt_status;
  chan_alarm_pkg::los_state_e analog_state_ff;
  chan_alarm_pkg::los_state_e digital_state_ff;
  logic [7:0] int_stat_ff;
  logic [7:0] int_mask_ff;
  logic [7:0] nxt_int_stat;
  logic [7:0] rise;
  logic [7:0] reg_rdata_ff;
  logic irq_ff;
  logic [4:0] sync_a_ff;
  logic [4:0] sync_b_ff;
  logic [4:0] sync_c_ff;
  logic [4:0] clk_evt;
  logic [7:0] zero_run_ff;
  logic [4:0] win_idx_ff;
  logic [5:0] win_ones_ff;
  logic [5:0] nxt_ones;
  logic [11:0] ref_cnt_ff;
  logic [11:0] recov_cnt_ff;
  logic [11:0] nxt_recov;
  logic lol_ff;
  logic ref_evt;
  logic recov_evt;
  logic [2:0] sel_key_cur;
  logic win_end;
  logic analog_los;
  logic digital_los;
  logic [2:0] sel_prev_ff;
  logic sel_change;
  logic [5:0] depth;
  logic fifo_near;

  assign req.addr = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr = reg_wr;
  assign req.rd = reg_rd;

  // clock toggle synchronisers and edge events
  // toggles must stay slower than half the clock or two events merge
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync_a_ff <= 5'h00;
      sync_b_ff <= 5'h00;
      sync_c_ff <= 5'h00;
    end else begin
      sync_a_ff <= {synth_line_clock, sts1_rate_ref_clock, ds3_rate_ref_clock,
                    e3_rate_ref_clock, recov_clk_toggle};
      sync_b_ff <= sync_a_ff;
      sync_c_ff <= sync_b_ff;
    end
  end

  assign clk_evt = sync_b_ff ^ sync_c_ff;
  assign recov_evt = clk_evt[0];

  // reference selection by rate or single-reference mode
  always_comb begin
    if (ctrl_ff.single_reference_synth_mode) begin
      ref_evt = clk_evt[4];
    end else begin
      unique case (ctrl_ff.rate)
        chan_alarm_pkg::RATE_E3: ref_evt = clk_evt[1];
        chan_alarm_pkg::RATE_DS3: ref_evt = clk_evt[2];
        chan_alarm_pkg::RATE_STS1: ref_evt = clk_evt[3];
        default: ref_evt = 1'b0;
      endcase
    end
  end

  assign sel_key_cur = {ctrl_ff.single_reference_synth_mode, ctrl_ff.rate};
  assign sel_change = (sel_key_cur != sel_prev_ff);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sel_prev_ff <= 3'h0;
    end else begin
      sel_prev_ff <= sel_key_cur;
    end
  end

  // frequency compare over a window of reference events
  // a reference change restarts the window, lol keeps its last verdict
  assign win_end = ref_evt && ref_cnt_ff == `LOL_WIN - 12'd1;

  assign nxt_recov = (recov_evt && recov_cnt_ff != 12'hfff) ? recov_cnt_ff + 12'd1
                                                             : recov_cnt_ff;

  always_ff @(posedge ref_clk) begin
    if (reset || sel_change) begin
      ref_cnt_ff <= 12'h000;
      recov_cnt_ff <= 12'h000;
    end else if (win_end) begin
      ref_cnt_ff <= 12'h000;
      recov_cnt_ff <= 12'h000;
    end else begin
      ref_cnt_ff <= ref_evt ? ref_cnt_ff + 12'd1 : ref_cnt_ff;
      recov_cnt_ff <= nxt_recov;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lol_ff <= 1'b0;
    end else if (win_end && !sel_change) begin
      lol_ff <= freq_off(nxt_recov);
    end
  end

  // analog detector with hysteresis
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      analog_state_ff <= chan_alarm_pkg::LOS_CLEAR;
    end else begin
      unique case (analog_state_ff)
        chan_alarm_pkg::LOS_CLEAR: begin
          if (analog_amp < `AMP_DECLARE) begin
            analog_state_ff <= chan_alarm_pkg::LOS_DECLARED;
          end
        end
        chan_alarm_pkg::LOS_DECLARED: begin
          if (analog_amp > `AMP_CLEAR) begin
            analog_state_ff <= chan_alarm_pkg::LOS_CLEAR;
          end
        end
      endcase
    end
  end

  // digital detector: zero run and density window
  // free-running window index, so a clear lands on a 32-bit boundary
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      zero_run_ff <= 8'h00;
    end else if (rx_bit_en) begin
      if (rx_pulse) begin
        zero_run_ff <= 8'h00;
      end else if (zero_run_ff != `DLOS_ZERO_RUN) begin
        zero_run_ff <= zero_run_ff + 8'd1;
      end
    end
  end

  assign nxt_ones = win_ones_ff + {5'h00, rx_pulse};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      win_idx_ff <= 5'h00;
      win_ones_ff <= 6'h00;
    end else if (rx_bit_en) begin
      win_idx_ff <= win_idx_ff + 5'd1;
      win_ones_ff <= (win_idx_ff == 5'h1f) ? 6'h00 : nxt_ones;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      digital_state_ff <= chan_alarm_pkg::LOS_CLEAR;
    end else if (rx_bit_en) begin
      unique case (digital_state_ff)
        chan_alarm_pkg::LOS_CLEAR: begin
          if (!rx_pulse && zero_run_ff == `DLOS_ZERO_RUN - 8'd1) begin
            digital_state_ff <= chan_alarm_pkg::LOS_DECLARED;
          end
        end
        chan_alarm_pkg::LOS_DECLARED: begin
          if (win_idx_ff == 5'h1f && density_ok(nxt_ones)) begin
            digital_state_ff <= chan_alarm_pkg::LOS_CLEAR;
          end
        end
      endcase
    end
  end

  // fifo limit check
  assign depth = ctrl_ff.fifo_deep ? `FIFO_DEPTH_LONG : `FIFO_DEPTH_SHORT;
  assign fifo_near = ctrl_ff.ja_enable &&
                     (ja_fifo_fill <= `FIFO_MARGIN ||
                      ja_fifo_fill >= depth - `FIFO_MARGIN);

  assign analog_los = (analog_state_ff == chan_alarm_pkg::LOS_DECLARED);
  assign digital_los = (digital_state_ff == chan_alarm_pkg::LOS_DECLARED);

  // live status, never latched
  always_comb begin
    nxt_status.analog = analog_los;
    nxt_status.fifo = fifo_near;
    nxt_status.recovered_clock_unlocked = lol_ff;
    nxt_status.comb = analog_los || digital_los;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status_ff <= 4'h0;
      prev_ff <= 4'h0;
    end else begin
      status_ff <= nxt_status;
      prev_ff <= status_ff;
    end
  end

  // control register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_ff <= `CTRL_RESET;
    end else if (wr_hit(req, `ADDR_CTRL)) begin
      ctrl_ff <= {3'h0, req.wdata[4:0]};
    end
  end

  // interrupt status: set wins over write-one clear
  assign rise = alarm_byte(status_ff) & ~alarm_byte(prev_ff);

  always_comb begin
    nxt_int_stat = int_stat_ff;
    if (wr_hit(req, `ADDR_INT_STAT)) begin
      nxt_int_stat = int_stat_ff & ~req.wdata;
    end
    nxt_int_stat = nxt_int_stat | rise;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      int_stat_ff <= `INT_RESET;
    end else begin
      int_stat_ff <= nxt_int_stat;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      int_mask_ff <= `INT_RESET;
    end else if (wr_hit(req, `ADDR_INT_MASK)) begin
      int_mask_ff <= req.wdata & alarm_byte(4'hf);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_int_stat & int_mask_ff);
    end
  end

  // read port; status writes fall through with no effect
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata_ff <= 8'h00;
    end else if (req.rd) begin
      unique case (req.addr)
        `ADDR_STATUS: reg_rdata_ff <= alarm_byte(status_ff);
        `ADDR_CTRL: reg_rdata_ff <= ctrl_ff;
        `ADDR_INT_STAT: reg_rdata_ff <= int_stat_ff;
        `ADDR_INT_MASK: reg_rdata_ff <= int_mask_ff;
        default: reg_rdata_ff <= 8'h00;
      endcase
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign irq = irq_ff;

endmodule

`default_nettype wire

//--- hw/chan_alarm_regs.svh
`ifndef CHAN_ALARM_REGS_SVH
`define CHAN_ALARM_REGS_SVH

// register byte addresses
`define ADDR_STATUS 8'h00
`define ADDR_CTRL 8'h01
`define ADDR_INT_STAT 8'h02
`define ADDR_INT_MASK 8'h03

// status and interrupt bit positions
`define BIT_ANALOG 4
`define BIT_FIFO 3
`define BIT_LOL 2
`define BIT_COMB 1

// reset values
`define STATUS_RESET 8'h00
`define CTRL_RESET 8'h01
`define INT_RESET 8'h00

// digital detector
`define DLOS_ZERO_RUN 8'd160
`define DLOS_WIN 6'd32
`define DLOS_DENSITY_PCT 7'd33

// analog detector thresholds, hysteresis between them
`define AMP_DECLARE 8'h30
`define AMP_CLEAR 8'h40

// fifo limit margin in bit periods
`define FIFO_MARGIN 6'd2
`define FIFO_DEPTH_SHORT 6'd16
`define FIFO_DEPTH_LONG 6'd32

// clock compare window and limit
`define LOL_WIN 12'd1024
`define LOL_LIMIT_PPM 40'd5000

`endif

//--- hw/chan_alarm_pkg.sv
package chan_alarm_pkg;

  typedef enum logic [1:0] {
    RATE_E3 = 2'h0,
    RATE_DS3 = 2'h1,
    RATE_STS1 = 2'h2
  } rate_e;

  typedef struct packed {
    logic [2:0] spare;
    logic fifo_deep;
    logic ja_enable;
    logic single_reference_synth_mode;
    logic [1:0] rate;
  } ctrl_s;

  typedef enum logic {
    LOS_CLEAR = 1'b0,
    LOS_DECLARED = 1'b1
  } los_state_e;

  typedef struct packed {
    logic analog;
    logic fifo;
    logic recovered_clock_unlocked;
    logic comb;
  } alarm_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

endpackage

//--- tb/chan_alarm_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module chan_alarm_monitor (
  input wire logic ref_clk, // clock
  input wire logic reset, // sync reset
  input wire logic [7:0] reg_addr, // address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic irq, // interrupt
  input wire logic [7:0] analog_amp, // amplitude
  input wire logic [5:0] ja_fifo_fill // fifo fill
);
  logic [7:0] ctrl_ff;
  logic [2:0] up_ff;
  logic fifo_exp;
  logic rs;
  // mirror of the control register
  always_ff @(posedge ref_clk) begin
    if (reset) ctrl_ff <= 8'h01;
    else if (reg_wr && reg_addr == 8'h01) ctrl_ff <= reg_wdata;
  end
  // cycles since reset, saturating
  always_ff @(posedge ref_clk) begin
    if (reset) up_ff <= 3'h0;
    else if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
  end
  assign rs = reg_rd && reg_addr == 8'h00 && up_ff == 3'h7;
  assign fifo_exp = ctrl_ff[3] && (ja_fifo_fill <= 6'h02
    || ja_fifo_fill >= (ctrl_ff[4] ? 6'h1e : 6'h0e));
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_idle_read: assert property ((!reg_rd || reg_addr > 8'h03) |=> reg_rdata == 8'h00)
    else $error("read data not zero");
  a_status_spare: assert property (rs |=> reg_rdata[7:5] == 3'h0 && !reg_rdata[0])
    else $error("spare status bits set");
  a_analog_declare: assert property (rs && analog_amp < 8'h30 && $past(analog_amp) < 8'h30
    && $past(analog_amp, 2) < 8'h30 |=> reg_rdata[4] && reg_rdata[1])
    else $error("analog loss not shown");
  a_analog_clear: assert property (rs && analog_amp > 8'h40 && $past(analog_amp) > 8'h40
    && $past(analog_amp, 2) > 8'h40 |=> !reg_rdata[4])
    else $error("analog loss not cleared");
  a_fifo_alarm: assert property (rs |=> reg_rdata[3] == $past(fifo_exp, 2))
    else $error("fifo alarm wrong");
  a_ctrl_readback: assert property (reg_rd && reg_addr == 8'h01
    |=> reg_rdata == (ctrl_ff & 8'h1f))
    else $error("control readback wrong");
  a_comb_covers: assert property ($past(reg_rd && reg_addr == 8'h00) && reg_rdata[4]
    |-> reg_rdata[1])
    else $error("combined loss missing");
  a_mask_quiet: assert property ((reg_wr && reg_addr == 8'h03 && reg_wdata == 8'h00)
    ##1 !(reg_wr && reg_addr == 8'h03) |=> !irq)
    else $error("irq high with mask clear");
endmodule
bind channel_alarm_status_bits chan_alarm_monitor i_mon (.ref_clk(ref_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq(irq), .analog_amp(analog_amp), .ja_fifo_fill(ja_fifo_fill));
`default_nettype wire

//--- tb/tb_channel_alarm_status_bits.sv
`timescale 1ns/1ps
`default_nettype none
module tb_channel_alarm_status_bits;
  logic ref_clk, reset, reg_wr, reg_rd, irq, rx_bit_en, rx_pulse, rec_t;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, analog_amp;
  logic [5:0] ja_fifo_fill;
  logic [3:0] ref_t;
  logic [7:0] cw;
  int mismatches, compares, per, bitn, k;
  int acc[5];
  int step[5];
  logic [8:0] atab[9] = '{9'h050, 9'h12f, 9'h135, 9'h140, 9'h041, 9'h035, 9'h030, 9'h12f, 9'h050};
  logic [5:0] ftab[8] = '{6'h00, 6'h02, 6'h03, 6'h0e, 6'h0d, 6'h1d, 6'h1e, 6'h20};
  logic [7:0] ctab[4] = '{8'h00, 8'h01, 8'h02, 8'h05};
  channel_alarm_status_bits i_dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .analog_amp(analog_amp), .rx_bit_en(rx_bit_en), .rx_pulse(rx_pulse),
    .ja_fifo_fill(ja_fifo_fill), .recov_clk_toggle(rec_t), .e3_rate_ref_clock(ref_t[0]),
    .ds3_rate_ref_clock(ref_t[1]), .sts1_rate_ref_clock(ref_t[2]),
    .synth_line_clock(ref_t[3]));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // bit stream and divided clock toggles from phase accumulators
  always @(posedge ref_clk) begin
    rx_bit_en <= !rx_bit_en;
    if (!rx_bit_en) bitn <= bitn + 1;
    rx_pulse <= per == 1 ? 1'($urandom % 2) : per > 1 && bitn % per == 0;
    for (int i = 0; i < 5; i++) begin
      acc[i] <= (acc[i] + step[i]) % 3000;
      if (acc[i] + step[i] >= 3000) begin
        if (i < 4) ref_t[i] <= !ref_t[i];
        else rec_t <= !rec_t;
      end
    end
  end
  function automatic logic fexp(logic [5:0] f, int c);
    return c > 0 && (f <= 6'h02 || f >= (c == 2 ? 6'h1e : 6'h0e));
  endfunction
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] m, logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    chk($sformatf("reg %h", a), reg_rdata & m, e);
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    cyc(60000);
    mismatches++;
    wrap_up;
  end
  initial begin
    {reset, reg_wr, reg_rd, rx_bit_en, rx_pulse, rec_t} = 6'h20;
    {reg_addr, reg_wdata, ref_t, bitn, per} = '0;
    analog_amp = 8'h50;
    ja_fifo_fill = 6'h08;
    acc = '{default: 0};
    step = '{default: 0};
    {mismatches, compares} = '0;
    void'($urandom(44));
    per = 1;
    cyc(8);
    reset <= 1'b0;
    rd(8'h00, 8'hff, 8'h00);
    rd(8'h01, 8'hff, 8'h01);
    rd(8'h02, 8'hff, 8'h00);
    rd(8'h03, 8'hff, 8'h00);
    rd(8'h9c, 8'hff, 8'h00);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'hff, 8'h00);
    analog_amp <= 8'h2f;
    cyc(4);
    rd(8'h00, 8'hff, 8'h12);
    rd(8'h02, 8'hff, 8'h12);
    chk("irq", {7'h0, irq}, 8'h00);
    wr(8'h03, 8'h10);
    cyc(2);
    chk("irq", {7'h0, irq}, 8'h01);
    wr(8'h02, 8'h10);
    cyc(2);
    chk("irq", {7'h0, irq}, 8'h00);
    rd(8'h02, 8'hff, 8'h02);
    wr(8'h03, 8'h00);
    for (int i = 0; i < 9; i++) begin
      analog_amp <= atab[i][7:0];
      cyc(4);
      rd(8'h00, 8'hff, atab[i][8] ? 8'h12 : 8'h00);
    end
    for (int c = 0; c < 3; c++) begin
      cw = c == 0 ? 8'h01 : c == 1 ? 8'h09 : 8'h19;
      wr(8'h01, cw);
      rd(8'h01, 8'hff, cw);
      for (int i = 0; i < 12; i++) begin
        ja_fifo_fill <= i < 8 ? ftab[i] : 6'($urandom % 33);
        cyc(2);
        rd(8'h00, 8'h08, {4'h0, fexp(ja_fifo_fill, c), 3'h0});
      end
    end
    ja_fifo_fill <= 6'h08;
    per <= 0;
    cyc(290);
    rd(8'h00, 8'h12, 8'h00);
    cyc(40);
    rd(8'h00, 8'h12, 8'h02);
    per <= 4;
    cyc(200);
    rd(8'h00, 8'h12, 8'h02);
    per <= 2;
    cyc(200);
    rd(8'h00, 8'h12, 8'h00);
    per <= 1;
    for (int s = 0; s < 6; s++) begin
      k = s < 2 ? 1 : s - 2;
      wr(8'h01, ctab[k]);
      rd(8'h01, 8'hff, ctab[k]);
      for (int i = 0; i < 4; i++) step[i] <= i == k ? 1000 : 900;
      step[4] <= s == 0 ? 1010 : s == 1 ? 1004 : 1000;
      cyc(7000);
      rd(8'h00, 8'h04, s == 0 ? 8'h04 : 8'h00);
    end
    wrap_up;
  end
endmodule
`default_nettype wire
